// ==== rtl/pixel_port.sv ====
// Purpose: multiplexed pixel input port with clock control
// Assumes: pixel_latch_strobe and pixel inputs synchronous to clk
// Notes: clk is the selected pixel clock (external or PLL)
`timescale 1ns/100ps
module pixel_port
	import pixel_port_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// register port
	input  wire logic [3:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic [7:0]                   reg_rdata,
	// pixel inputs
	input  wire logic                    pixel_latch_strobe,
	input  wire logic [WORDS*WORD_W-1:0] pixel_color,
	input  wire logic [SEL_W-1:0]        palette_select,
	input  wire logic                    blank_n,
	input  wire logic                    sync_n,
	input  wire logic                    tri_level_sync_n,
	// clock outputs and shift clock input
	output logic                         latch_strobe_out,
	output logic                         programmable_clock_out,
	input  wire logic                    shift_clock_in,
	output logic                         gated_shift_clock_out,
	// video towards the palette and converters
	output video_out_t                   video_out,
	output logic                         digital_sync_out
);

	logic [7:0]          cmd1_q;
	logic [7:0]          cmd2_q;
	logic [7:0]          mode_q;
	cmd1_t               cmd1;
	cmd2_t               cmd2;
	mode_t               mode;
	cmd2_t               cmd2_wr;
	mode_t               mode_wr;
	logic [2:0]          wr_last_pix;
	mux_t                rate;
	sel_func_t           func;
	logic                pseudo8;
	logic [2:0]          phase;
	logic [2:0]          last_pix;
	logic                strobe_q;
	logic                strobe_edge;
	capture_t            hold_q;
	capture_t            shift_q;
	logic                hold_full_q;
	logic                unload;
	logic [2:0]          unload_phase_q;
	logic [2:0]          pix_idx_q;
	logic                active_q;
	cal_state_t          cal_state_q;
	logic                calib_done_q;
	logic                sync_seen_q;
	logic                vsync_start;
	logic [1:0]          ps_bits;
	logic [WORD_W-1:0]   pix_color;
	pix_ctl_t            pix_ctl;
	logic [2:0]          sync_en;

	// rate select bits {hi, lo} to multiplex rate
	function automatic mux_t decode_rate(input logic [1:0] sel);
		mux_t r;
		unique case (sel)
			2'h0:    r = MUX_2;
			2'h2:    r = MUX_8;
			default: r = MUX_4;
		endcase
		return r;
	endfunction

	// index of the last pixel in one load
	function automatic logic [2:0] last_index(input mux_t r);
		logic [2:0] idx;
		unique case (r)
			MUX_2:   idx = 3'h1;
			MUX_8:   idx = 3'h7;
			default: idx = 3'h3;
		endcase
		return idx;
	endfunction

	// select pair of pixel j from a byte laid out as {ps1 x4, ps0 x4}
	function automatic logic [1:0] pair_bits(input logic [7:0] v, input logic [1:0] j);
		return {v[3'h4 + {1'b0, j}], v[j]};
	endfunction

	assign cmd1 = cmd1_t'(cmd1_q);
	assign cmd2 = cmd2_t'(cmd2_q);
	assign mode = mode_t'(mode_q);

	// views of the byte being written
	assign cmd2_wr     = cmd2_t'(reg_wdata);
	assign mode_wr     = mode_t'(reg_wdata);
	assign wr_last_pix = last_index(decode_rate({cmd2_wr.mux_rate_sel_hi, cmd2_wr.mux_rate_sel_lo}));

	// mux rate and select function decode
	always_comb begin
		rate = decode_rate({cmd2.mux_rate_sel_hi, cmd2.mux_rate_sel_lo});
		unique case ({cmd1.select_function_hi, cmd1.select_function_lo})
			2'h0: func = SEL_PALETTE;
			2'h1: func = SEL_BYPASS;
			2'h2: func = SEL_OVERLAY;
			2'h3: func = SEL_IGNORE;
		endcase
	end

	// 8:1 implies 8-bit pseudo colour
	assign pseudo8 = (rate == MUX_8);
	assign last_pix = last_index(rate);
	assign sync_en = {cmd1.sync_on_blue_en, cmd1.sync_on_green_en, cmd1.sync_on_red_en};

	clock_divider u_div (
		.clk                    (clk),
		.reset                  (reset),
		.rate                   (rate),
		.prg_div_sel            (cmd2.prg_div_sel),
		.phase                  (phase),
		.latch_strobe_out       (latch_strobe_out),
		.programmable_clock_out (programmable_clock_out)
	);

	// register writes
	always_ff @(posedge clk) begin
		if (reset) begin
			cmd1_q <= CMD1_RESET;
			cmd2_q <= CMD2_RESET;
			mode_q <= MODE_RESET;
		end else if (reg_write) begin
			unique case (reg_addr)
				REG_CMD1: cmd1_q <= reg_wdata;
				REG_CMD2: cmd2_q <= reg_wdata;
				REG_MODE: mode_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// register reads, data one cycle later
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			unique case (reg_addr)
				REG_CMD1:   reg_rdata <= cmd1_q;
				REG_CMD2:   reg_rdata <= cmd2_q;
				REG_MODE:   reg_rdata <= mode_q;
				REG_STATUS: reg_rdata <= {2'h0, hold_full_q, cal_state_q != CAL_IDLE,
				                          calib_done_q, unload_phase_q};
				default:    reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// strobe edge detect and capture
	assign strobe_edge = pixel_latch_strobe & ~strobe_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= pixel_latch_strobe;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			hold_q <= '0;
		end else if (strobe_edge) begin
			hold_q.color            <= pixel_color;
			hold_q.palette_select   <= palette_select;
			hold_q.blank_n          <= blank_n;
			hold_q.sync_n           <= sync_n;
			hold_q.tri_level_sync_n <= tri_level_sync_n;
		end
	end

	// a load waits for the next unload slot, so any strobe phase works
	assign unload = hold_full_q && (phase == unload_phase_q);

	always_ff @(posedge clk) begin
		if (reset) begin
			hold_full_q <= 1'b0;
		end else if (strobe_edge) begin
			hold_full_q <= 1'b1;
		end else if (unload) begin
			hold_full_q <= 1'b0;
		end
	end

	// vertical sync start for per-sync calibration
	assign vsync_start = strobe_edge & ~sync_n & sync_seen_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			sync_seen_q <= 1'b0;
		end else if (strobe_edge) begin
			sync_seen_q <= sync_n;
		end
	end

	// calibration sequencing
	always_ff @(posedge clk) begin
		if (reset) begin
			cal_state_q <= CAL_IDLE;
		end else begin
			unique case (cal_state_q)
				CAL_IDLE: begin
					if (reg_write && reg_addr == REG_MODE && mode_wr.calib_arm_bit) begin
						cal_state_q <= CAL_ARMED;
					end else if (cmd1.calib_per_vsync_en && !mode.calib_trigger_bit && vsync_start) begin
						cal_state_q <= CAL_WAIT_EDGE;
					end
				end
				CAL_ARMED: begin
					if (reg_write && reg_addr == REG_MODE && mode_wr.calib_trigger_bit) begin
						cal_state_q <= CAL_WAIT_EDGE;
					end
				end
				CAL_WAIT_EDGE: begin
					if (strobe_edge) begin
						cal_state_q <= CAL_IDLE;
					end
				end
				default: cal_state_q <= CAL_IDLE;
			endcase
		end
	end

	// place unload one cycle after the observed edge
	always_ff @(posedge clk) begin
		if (reset) begin
			unload_phase_q <= FIXED_PHASE;
			calib_done_q   <= 1'b0;
		end else if (cal_state_q == CAL_WAIT_EDGE && strobe_edge) begin
			unload_phase_q <= (phase + 3'h1) & last_pix;
			calib_done_q   <= 1'b1;
		end else if (reg_write && reg_addr == REG_CMD2) begin
			// fixed slot must fit the rate being written, else no load is ever unloaded
			unload_phase_q <= FIXED_PHASE & wr_last_pix;
			calib_done_q   <= 1'b0;
		end
	end

	// serialiser on the pixel clock
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_q   <= '0;
			pix_idx_q <= 3'h0;
			active_q  <= 1'b0;
		end else if (unload) begin
			shift_q   <= hold_q;
			pix_idx_q <= 3'h0;
			active_q  <= 1'b1;
		end else if (pix_idx_q != last_pix) begin
			pix_idx_q <= pix_idx_q + 3'h1;
		end else begin
			active_q  <= 1'b0;
		end
	end

	// per-pixel colour and select bits
	always_comb begin
		pix_color = '0;
		ps_bits   = 2'h0;
		if (pseudo8) begin
			if (pix_idx_q[2]) begin
				pix_color = {16'h0000, shift_q.color[pix_idx_q[1:0]*WORD_W+8 +: 8]};
				// extra selects for pixels 4 to 7 on the blue byte of the first word, used only at 8:1
				ps_bits   = pair_bits(shift_q.color[7:0], pix_idx_q[1:0]);
			end else begin
				pix_color = {16'h0000, shift_q.color[pix_idx_q[1:0]*WORD_W+16 +: 8]};
				ps_bits   = pair_bits(shift_q.palette_select, pix_idx_q[1:0]);
			end
		end else begin
			pix_color = shift_q.color[pix_idx_q[1:0]*WORD_W +: WORD_W];
			ps_bits   = pair_bits(shift_q.palette_select, pix_idx_q[1:0]);
		end
	end

	pixel_select_decode u_sel (
		.func    (func),
		.pseudo8 (pseudo8),
		.match   ({mode.palette_match_bit1, mode.palette_match_bit0}),
		.ps      (ps_bits),
		.ctl     (pix_ctl)
	);

	// video output stage, sync follows the same pipeline
	always_ff @(posedge clk) begin
		if (reset) begin
			video_out        <= '0;
			digital_sync_out <= 1'b1;
		end else begin
			video_out.color       <= active_q ? pix_color : '0;
			video_out.color_mode  <= cmd1.bypass_mode_lo ? {cmd1.tri_level_enable_bypass_hi,
			                         cmd1.bypass_mode_lo, 2'h0} : cmd2.palette_color_mode;
			video_out.ctl         <= pix_ctl;
			video_out.blank       <= ~shift_q.blank_n;
			video_out.sync_rgb    <= {3{~shift_q.sync_n}} & sync_en;
			video_out.tri_level_sync_n_rgb <= {3{cmd1.tri_level_enable_bypass_hi & ~shift_q.tri_level_sync_n}}
			                         & sync_en;
			digital_sync_out      <= shift_q.sync_n;
		end
	end

	// shift clock gated by blank
	always_ff @(posedge clk) begin
		if (reset) begin
			gated_shift_clock_out <= 1'b0;
		end else begin
			gated_shift_clock_out <= shift_clock_in & blank_n;
		end
	end

endmodule

// ==== rtl/pixel_port_pkg.sv ====
// Purpose: shared constants and types of the pixel port and clock control block
// Assumes: 8-bit register port, one pixel clock
// Notes:
package pixel_port_pkg;

	localparam logic [3:0] REG_CMD1   = 4'h0;
	localparam logic [3:0] REG_CMD2   = 4'h4;
	localparam logic [3:0] REG_MODE   = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;

	localparam logic [7:0] CMD1_RESET = 8'h20;
	localparam logic [7:0] CMD2_RESET = 8'h10;
	localparam logic [7:0] MODE_RESET = 8'h00;

	localparam int unsigned WORD_W     = 24;
	localparam int unsigned WORDS      = 4;
	localparam int unsigned SEL_W      = 8;
	localparam int unsigned PIX_MAX    = 8;
	localparam logic [2:0]  FIXED_PHASE = 3'h2;

	typedef struct packed {
		logic sync_on_blue_en;
		logic sync_on_red_en;
		logic sync_on_green_en;
		logic calib_per_vsync_en;
		logic tri_level_enable_bypass_hi;
		logic bypass_mode_lo;
		logic select_function_hi;
		logic select_function_lo;
	} cmd1_t;

	typedef struct packed {
		logic [1:0] prg_div_sel;
		logic       mux_rate_sel_hi;
		logic       mux_rate_sel_lo;
		logic [3:0] palette_color_mode;
	} cmd2_t;

	typedef struct packed {
		logic [3:0] spare;
		logic       palette_match_bit1;
		logic       palette_match_bit0;
		logic       calib_trigger_bit;
		logic       calib_arm_bit;
	} mode_t;

	typedef enum logic [1:0] {MUX_2, MUX_4, MUX_8} mux_t;
	typedef enum logic [1:0] {SEL_PALETTE, SEL_BYPASS, SEL_OVERLAY, SEL_IGNORE} sel_func_t;
	typedef enum logic [1:0] {CAL_IDLE, CAL_ARMED, CAL_WAIT_EDGE} cal_state_t;

	typedef struct packed {
		logic [WORDS*WORD_W-1:0] color;
		logic [SEL_W-1:0]        palette_select;
		logic                    blank_n;
		logic                    sync_n;
		logic                    tri_level_sync_n;
	} capture_t;

	typedef struct packed {
		logic       shutdown;
		logic       bypass;
		logic [1:0] overlay_idx;
	} pix_ctl_t;

	typedef struct packed {
		logic [WORD_W-1:0] color;
		logic [3:0]        color_mode;
		pix_ctl_t          ctl;
		logic              blank;
		logic [2:0]        sync_rgb;
		logic [2:0]        tri_level_sync_n_rgb;
	} video_out_t;

endpackage

// ==== rtl/clock_divider.sv ====
// Purpose: load strobe and programmable clock dividers
// Assumes: one pixel clock, rates from the command registers
// Notes: strobe and programmable clock outputs registered (phase is not), rising together at count zero
`timescale 1ns/100ps
module clock_divider
	import pixel_port_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// settings
	input  wire mux_t       rate,
	input  wire logic [1:0] prg_div_sel,
	// outputs
	output logic [2:0]      phase,
	output logic            latch_strobe_out,
	output logic            programmable_clock_out
);

	logic [4:0] tick_q;
	logic [4:0] tick_d;
	logic [2:0] mask;
	logic [4:0] prg_mask;

	always_comb begin
		unique case (rate)
			MUX_2:   mask = 3'h1;
			MUX_8:   mask = 3'h7;
			default: mask = 3'h3;
		endcase
		unique case (prg_div_sel)
			2'h0: prg_mask = 5'h03;
			2'h1: prg_mask = 5'h07;
			2'h2: prg_mask = 5'h0f;
			2'h3: prg_mask = 5'h1f;
		endcase
	end

	assign tick_d = tick_q + 5'h1;
	assign phase  = tick_q[2:0] & mask;

	always_ff @(posedge clk) begin
		if (reset) begin
			tick_q <= 5'h00;
		end else begin
			tick_q <= tick_d;
		end
	end

	// high for first half of each period
	always_ff @(posedge clk) begin
		if (reset) begin
			latch_strobe_out       <= 1'b0;
			programmable_clock_out <= 1'b0;
		end else begin
			latch_strobe_out       <= (tick_d[2:0] & mask) <= (mask >> 1);
			programmable_clock_out <= (tick_d & prg_mask) <= (prg_mask >> 1);
		end
	end

endmodule

// ==== rtl/pixel_select_decode.sv ====
// Purpose: per-pixel meaning of the two select bits
// Assumes: select function already decoded
// Notes: combinational
`timescale 1ns/100ps
module pixel_select_decode
	import pixel_port_pkg::*;
(
	// setup
	input  wire sel_func_t  func,
	input  wire logic       pseudo8,
	input  wire logic [1:0] match,
	// pixel select bits {ps1, ps0}
	input  wire logic [1:0] ps,
	// result
	output pix_ctl_t        ctl
);

	always_comb begin
		ctl = '0;
		unique case (func)
			SEL_PALETTE: ctl.shutdown = (ps != match);
			SEL_BYPASS: begin
				if (ps[0]) begin
					ctl.overlay_idx = 2'h1;
				end else begin
					ctl.bypass = ps[1] & ~pseudo8;
				end
			end
			SEL_OVERLAY: ctl.overlay_idx = ps;
			SEL_IGNORE:  ctl = '0;
		endcase
	end

endmodule

// ==== dv/pixel_source.sv ====
// Purpose: frame buffer side model that returns the load strobe
// Assumes: pixel data lines are driven by the bench at all times
// Notes: lag sets how late the strobe comes back, shift clock is one cycle late at any lag
`timescale 1ns/100ps
module pixel_source (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// strobe path
	input  wire logic       latch_strobe_out,
	input  wire logic [2:0] lag,
	output logic            pixel_latch_strobe,
	output logic            shift_clock_in
);
	logic [7:0] dly_q;

	always_ff @(posedge clk) begin
		if (reset)
			dly_q <= 8'h00;
		else
			dly_q <= {dly_q[6:0], latch_strobe_out};
	end

	// strobe comes back at the divided rate, late by lag + 1 cycles
	assign pixel_latch_strobe = dly_q[lag];
	assign shift_clock_in     = dly_q[0];
endmodule

// ==== dv/pixel_port_sva.sv ====
// Purpose: port-level checks of the pixel port
// Assumes: command registers shadowed from the register port
// Notes: mode-dependent checks wait 31 quiet cycles after a write
`timescale 1ns/100ps
module pixel_port_sva
	import pixel_port_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       blank_n,
	input wire logic       shift_clock_in,
	input wire logic       latch_strobe_out,
	input wire logic       programmable_clock_out,
	input wire logic       gated_shift_clock_out,
	input wire video_out_t video_out,
	input wire logic       digital_sync_out
);
	logic [7:0] cmd1_q;
	logic [7:0] cmd2_q;
	logic [4:0] quiet_q;
	logic [5:0] ratio;
	logic [5:0] ndiv;
	logic [2:0] sync_en;
	logic       calm;

	always_ff @(posedge clk) begin
		if (reset) begin
			cmd1_q  <= CMD1_RESET;
			cmd2_q  <= CMD2_RESET;
			quiet_q <= 5'h00;
		end else if (reg_write) begin
			quiet_q <= 5'h00;
			if (reg_addr == REG_CMD1)
				cmd1_q <= reg_wdata;
			if (reg_addr == REG_CMD2)
				cmd2_q <= reg_wdata;
		end else if (quiet_q != 5'h1f) begin
			quiet_q <= quiet_q + 5'h01;
		end
	end

	assign ratio   = (cmd2_q[5:4] == 2'h0) ? 6'h02 : (cmd2_q[5:4] == 2'h2) ? 6'h08 : 6'h04;
	assign ndiv    = 6'h04 << cmd2_q[7:6];
	assign sync_en = {cmd1_q[7], cmd1_q[5], cmd1_q[6]};
	assign calm    = quiet_q == 5'h1f;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_rate_two: assert property (disable iff (reset || (reg_write && reg_addr == REG_CMD2))
		calm && ratio == 6'h02 && $rose(latch_strobe_out) |=> !latch_strobe_out ##1 latch_strobe_out)
		else $error("load strobe out of step at 2:1");
	a_rate_four: assert property (disable iff (reset || (reg_write && reg_addr == REG_CMD2))
		calm && ratio == 6'h04 && $rose(latch_strobe_out) |=>
		latch_strobe_out ##1 !latch_strobe_out[*2] ##1 latch_strobe_out)
		else $error("load strobe out of step at 4:1");
	a_rate_eight: assert property (disable iff (reset || (reg_write && reg_addr == REG_CMD2))
		calm && ratio == 6'h08 && $rose(latch_strobe_out) |=>
		latch_strobe_out[*3] ##1 !latch_strobe_out[*4] ##1 latch_strobe_out)
		else $error("load strobe out of step at 8:1");
	a_prg_aligned: assert property (calm && ndiv >= ratio && $rose(programmable_clock_out)
		|-> $rose(latch_strobe_out))
		else $error("programmable clock edge not on load strobe edge");
	a_prg_four: assert property (disable iff (reset || (reg_write && reg_addr == REG_CMD2))
		calm && ndiv == 6'h04 && $rose(programmable_clock_out) |=>
		programmable_clock_out ##1 !programmable_clock_out[*2] ##1 programmable_clock_out)
		else $error("programmable clock not divided by four");
	a_shift_gated: assert property (!$past(reset)
		|-> gated_shift_clock_out == ($past(shift_clock_in) && $past(blank_n)))
		else $error("shift clock not gated by blank");
	a_sync_pin: assert property (|video_out.sync_rgb |-> !digital_sync_out)
		else $error("digital sync out of step with video sync");
	a_sync_enables: assert property (calm |-> (video_out.sync_rgb & ~sync_en) == 3'h0)
		else $error("sync on a channel without enable");
	a_tri_level_sync_n_gate: assert property (calm |-> (video_out.tri_level_sync_n_rgb & ~({3{cmd1_q[3]}} & sync_en)) == 3'h0)
		else $error("tri-level sync without enable");
	a_shutdown_mode: assert property (calm && video_out.ctl.shutdown |-> cmd1_q[1:0] == 2'h0)
		else $error("shutdown outside palette select mode");
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside read answer cycle");

	c_rate_eight: cover property (calm && ratio == 6'h08 && $rose(latch_strobe_out));
	c_shutdown: cover property (video_out.ctl.shutdown);
	c_tri_level_sync_n: cover property (|video_out.tri_level_sync_n_rgb);
endmodule

bind pixel_port pixel_port_sva pixel_port_sva_inst (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .blank_n, .shift_clock_in, .latch_strobe_out, .programmable_clock_out, .gated_shift_clock_out,
	.video_out, .digital_sync_out);

// ==== dv/pixel_port_tb.sv ====
// Purpose: self-checking bench of the pixel port
// Assumes: strobe returned by the source model, data held steady
// Notes: pixel streams are found by scanning for the first pixel
`timescale 1ns/100ps
module pixel_port_tb
	import pixel_port_pkg::*;
;
	logic                    clk, reset, reg_write, reg_read, blank_n, sync_n, tri_level_sync_n;
	logic [3:0]              reg_addr;
	logic [7:0]              reg_wdata, reg_rdata, palette_select;
	logic [WORDS*WORD_W-1:0] pixel_color;
	logic                    pixel_latch_strobe, latch_strobe_out, programmable_clock_out;
	logic                    shift_clock_in, gated_shift_clock_out, digital_sync_out;
	logic [2:0]              lag;
	video_out_t              video_out;
	int                      miscompares, n_compared, rate, r, f, k;
	int                      rates[3] = '{4, 2, 8};
	logic [7:0]              cmds[3]  = '{8'h10, 8'h40, 8'ha0};
	logic [15:0]             ctab[5]  = '{16'h2050, 16'he078, 16'h0000, 16'h4881, 16'ha836};

	pixel_port pixel_port_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pixel_latch_strobe(pixel_latch_strobe),
		.pixel_color(pixel_color), .palette_select(palette_select), .blank_n(blank_n), .sync_n(sync_n),
		.tri_level_sync_n(tri_level_sync_n), .latch_strobe_out(latch_strobe_out),
		.programmable_clock_out(programmable_clock_out), .shift_clock_in(shift_clock_in),
		.gated_shift_clock_out(gated_shift_clock_out), .video_out(video_out), .digital_sync_out(digital_sync_out));
	pixel_source pixel_source_inst (.clk(clk), .reset(reset), .latch_strobe_out(latch_strobe_out), .lag(lag),
		.pixel_latch_strobe(pixel_latch_strobe), .shift_clock_in(shift_clock_in));

	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		check({24'h0, reg_rdata}, {24'h0, exp});
	endtask

	task automatic settle();
		repeat (40) @(posedge clk);
		#1;
	endtask

	// expected {ctl, color} of pixel i under select function fn
	function automatic logic [27:0] pix(input int i, input logic [1:0] fn);
		logic [23:0] c;
		logic [1:0]  s;
		logic [3:0]  q;
		c = pixel_color[24*i +: 24];
		s = {palette_select[4+i], palette_select[i]};
		if (rate == 8) begin
			c = {16'h0, pixel_color[24*(i%4) + (i < 4 ? 16 : 8) +: 8]};
			if (i >= 4)
				s = {pixel_color[i], pixel_color[i-4]};
		end
		case (fn)
			2'h0: q = {s != 2'h1, 3'h0};
			2'h1: q = s[0] ? 4'h1 : {1'b0, s[1] && rate != 8, 2'h0};
			2'h2: q = {2'h0, s};
			default: q = 4'h0;
		endcase
		return {q, c};
	endfunction

	task automatic stream(input logic [1:0] fn);
		int t;
		int i;
		t = 0;
		settle();
		while ({video_out.ctl, video_out.color} !== pix(0, fn) && t < 80) begin
			@(posedge clk);
			#1;
			t++;
		end
		for (i = 0; i < rate; i++) begin
			check({4'h0, video_out.ctl, video_out.color}, {4'h0, pix(i, fn)});
			@(posedge clk);
			#1;
		end
		$display("stream fn=%0d rate=%0d done", fn, rate);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end

	initial begin
		{reset, reg_write, reg_read, reg_addr, reg_wdata, lag} = {1'b1, 17'h00000};
		{blank_n, sync_n, tri_level_sync_n} = 3'h7;
		pixel_color    = 96'h432313_422212_412111_402010;
		palette_select = 8'h35;
		rate           = 4;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rdchk(REG_CMD1, CMD1_RESET);
		rdchk(REG_CMD2, CMD2_RESET);
		rdchk(REG_MODE, MODE_RESET);
		wr(4'h2, 8'hff);
		rdchk(4'h2, 8'h00);
		$display("register test done");
		for (r = 0; r < 3; r++) begin
			rate = rates[r];
			lag <= 3'(r * 2);
			wr(REG_CMD2, cmds[r]);
			wr(REG_MODE, 8'h01);
			wr(REG_MODE, 8'h06);
			for (f = 0; f < 4; f++) begin
				wr(REG_CMD1, {6'h08, 2'(f)});
				stream(2'(f));
			end
		end
		rate = 4;
		wr(REG_CMD2, 8'hde);
		blank_n <= 1'b0;
		settle();
		check({31'h0, video_out.blank}, 32'h1);
		check({31'h0, gated_shift_clock_out}, 32'h0);
		@(posedge clk);
		blank_n <= 1'b1;
		for (k = 0; k < 5; k++) begin
			wr(REG_CMD1, ctab[k][15:8]);
			sync_n           <= ctab[k][7];
			tri_level_sync_n <= ctab[k][6];
			settle();
			check({29'h0, video_out.sync_rgb}, {29'h0, ctab[k][5:3]});
			check({29'h0, video_out.tri_level_sync_n_rgb}, {29'h0, ctab[k][2:0]});
			check({31'h0, digital_sync_out}, {31'h0, ctab[k][7]});
		end
		check({28'h0, video_out.color_mode}, 32'he);
		wr(REG_CMD1, 8'h0c);
		settle();
		check({28'h0, video_out.color_mode}, 32'hc);
		$display("sync table done");
		lag <= 3'h5;
		wr(REG_CMD1, 8'h30);
		wr(REG_MODE, 8'h04);
		sync_n <= 1'b0;
		repeat (8) @(posedge clk);
		sync_n <= 1'b1;
		stream(2'h0);
		summarize();
	end
endmodule
